// >>> aais_pkg.sv
// Constants and types for the auxiliary analog input scaling block
package aais_pkg;
   localparam int ADDR_W = 12;
   // Register indices, byte address is four times the index
   localparam logic [9:0] IDX_PRESET2 = 10'h119;
   localparam logic [9:0] IDX_MGAIN = 10'h13c;
   localparam logic [9:0] IDX_MBIAS = 10'h13d;
   localparam logic [9:0] IDX_VGAIN = 10'h144;
   localparam logic [9:0] IDX_VBIAS = 10'h145;
   localparam logic [9:0] IDX_CGAIN = 10'h147;
   localparam logic [9:0] IDX_CBIAS = 10'h148;
   localparam logic [9:0] IDX_FUNC = 10'h14d;
   localparam logic [9:0] IDX_TYPE = 10'h14e;
   localparam logic [9:0] IDX_SPAN = 10'h14f;
   localparam logic [9:0] IDX_MAXF = 10'h1f0;
   localparam logic [9:0] IDX_SRC = 10'h1f1;
   localparam logic [9:0] IDX_STAT = 10'h1f2;
   localparam logic [9:0] IDX_ERRC = 10'h1f3;
   localparam logic [9:0] IDX_REF = 10'h1f4;
   // Source register fields
   localparam int SRC_FREQ_LSB = 0;
   localparam int SRC_PIDFB_LSB = 4;
   localparam int SRC_PIDC_LSB = 8;
   // Status register bits
   localparam int STAT_ERR = 0;
   localparam int STAT_ON = 1;
   localparam int STAT_BUSY = 2;
   // Reset values
   localparam logic [15:0] RST_GAIN = 16'h0064;
   localparam logic [15:0] RST_BIAS = 16'h0000;
   localparam logic [15:0] RST_SPAN = 16'h000a;
   localparam logic [15:0] RST_MAXF = 16'h01f4;
   // Setting limits, in percent except the function and type maxima
   localparam int GAIN_LIM = 255;
   localparam int BIAS_LIM = 100;
   localparam int SPAN_MAX = 50;
   localparam int MBIAS_LIM = 99;
   localparam int FUNC_MAX = 4;
   localparam int TYPE_MAX = 1;
   // Function, type and source codes
   localparam logic [15:0] FUNC_OFF = 16'h0000;
   localparam logic [15:0] FUNC_AUX_REF = 16'h0001;
   localparam logic [15:0] FUNC_GAIN = 16'h0002;
   localparam logic [15:0] FUNC_BIAS = 16'h0003;
   localparam logic [15:0] FUNC_VBIAS = 16'h0004;
   localparam logic [15:0] TYPE_CURR = 16'h0001;
   localparam logic [3:0] SRC_AUX_V = 4'h7;
   localparam logic [3:0] SRC_AUX_I = 4'h8;
   localparam logic [3:0] PID_FB_AUX_V = 4'h7;
   localparam logic [3:0] PID_FB_AUX_I = 4'h8;
   // Arbitrary code for the operation-setting error
   localparam logic [15:0] ERR_CODE_SETTING = 16'h0f06;
   // Arithmetic: percent in Q8, divide by 100 via reciprocal
   localparam int Q_SH = 8;
   localparam logic signed [47:0] PCT_FULL_Q8 = 48'sh6400;
   localparam logic signed [47:0] PCT_100 = 48'sh64;
   localparam logic signed [47:0] VBIAS_FULL = 48'sh64;
   localparam logic signed [63:0] DIV100_MUL = 64'sha3d7;
   localparam int DIV100_SH = 22;

   typedef enum logic [2:0] {
      PH_IDLE, PH_SUM, PH_MUL, PH_SCALE, PH_OUT
   } aais_phase_type;

   typedef struct packed {
      logic [15:0] vgain, vbias, cgain, cbias, func, itype, span;
      logic [15:0] mgain, mbias, preset2, maxf, src;
   } aais_cfg_type;

   typedef struct packed {
      logic [15:0] freq_two, aux_freq, gain_eff, bias_eff;
      logic [15:0] volt_bias, ref_pct;
      logic sel_aux, set_err, ref_valid;
   } aais_out_type;

   typedef struct packed {
      aais_phase_type ph;
      aais_cfg_type cfg;
      aais_out_type o;
      logic neg;
      logic [15:0] sb;
      logic [7:0] mag;
      logic signed [47:0] acc;
      logic [15:0] aux_freq, g_aux, b_aux, v_aux, ref_pct;
      logic [1:0] sync;
      logic [31:0] prdata;
      logic pslverr;
   } aais_state_type;

   localparam aais_cfg_type CFG_RST = '{vgain: RST_GAIN, vbias: RST_BIAS,
      cgain: RST_GAIN, cbias: RST_BIAS, func: FUNC_OFF, itype: 16'h0000,
      span: RST_SPAN, mgain: RST_GAIN, mbias: RST_BIAS, preset2: 16'h0000,
      maxf: RST_MAXF, src: 16'h0000};
endpackage : aais_pkg

// >>> aais_src_model.sv
// Analog source model: hands converter codes to the scaler
`timescale 1ns/1ps
module aais_src_model #(
   parameter int ADC_W = 12
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire logic curr_sel_i,
   input wire logic [ADC_W-1:0] code_i,
   output logic [ADC_W-1:0] volt_sample_o,
   output logic [ADC_W-1:0] curr_sample_o,
   output logic sample_valid_o
);
   logic [ADC_W-1:0] noise_ff;
   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         noise_ff <= '0;
         sample_valid_o <= 1'b0;
         volt_sample_o <= '0;
         curr_sample_o <= '0;
      end else begin
         noise_ff <= noise_ff + ADC_W'(12'h5a7);
         sample_valid_o <= req_i;
         volt_sample_o <= curr_sel_i ? noise_ff : code_i;
         curr_sample_o <= curr_sel_i ? code_i : ~noise_ff;
      end
   end
endmodule : aais_src_model

// >>> aais_top.sv
// Auxiliary analog input scaling with APB register slave
//
// Overview of operation
// - Function zero: auxiliary input affects no reference or voltage, except as the frequency source.
// - Aux assigned while frequency source or PID feedback uses it: error.
// - PID control enabled with nonzero function raises the error.
// - Function one: scaled input replaces preset speed two.
// - Multi-step input chooses main or auxiliary reference.
// - Function two: input is main gain factor, zero to two times.
// - Main gain multiplied by factor, main bias shifted by aux bias.
// - Function three: input is bias from minus to plus span.
// - Bias span is a percent of maximum frequency.
// - Function four: input adds 0 to 100 V output voltage bias.
// - Type zero selects voltage input, type one current input.
// - Voltage and current inputs use their own gain and bias.
// - Positive gain: reference is (input plus bias) times gain.
// - Negative gain: reference is 100 minus that product.
// - Full scale voltage or current code equals one hundred percent.
// - Reference used as frequency is a fraction of maximum frequency.
// - Negative reference clamps to zero.
// - Input gains span plus minus 255 percent, main gain 0 to 255, default 100.
// - Input biases span plus minus 100 percent, main bias plus minus 99, default zero.
// - Bias span 0 to 50 percent, default 10.
`timescale 1ns/1ps
module aais_top #(
   parameter int ADC_W = 12
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [aais_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [ADC_W-1:0] volt_sample_i,
   input wire logic [ADC_W-1:0] curr_sample_i,
   input wire logic sample_valid_i,
   input wire logic step_two_sel_i,
   output aais_pkg::aais_out_type ref_o
);
   import aais_pkg::*;

   // Elaboration guard: 48-bit accumulator sized for at most 16 bits
   if (ADC_W < 8 || ADC_W > 16) begin : g_adc_w_check
      $error("ADC_W must lie between 8 and 16");
   end

   aais_state_type s_ff;
   aais_state_type nxt_s;

   logic [9:0] idx;
   logic hit;
   logic ro_hit;
   logic [3:0] fsrc;
   logic [3:0] pidfb;
   logic [3:0] pidc;
   logic claim;
   logic err;
   logic on;
   logic take;
   logic signed [47:0] rp;
   logic signed [47:0] t;
   logic [ADC_W-1:0] raw;
   logic [15:0] sel_gain;

   function automatic logic [15:0] sat(input logic [15:0] v,
                                       input int lo, input int hi);
      int x;
      x = int'($signed(v));
      if (x < lo) begin
         return 16'(lo);
      end
      if (x > hi) begin
         return 16'(hi);
      end
      return v;
   endfunction : sat

   // Reciprocal multiply avoids a divider; floors toward minus
   function automatic logic signed [47:0] div100(
      input logic signed [47:0] x);
      logic signed [63:0] p;
      p = (x * DIV100_MUL) >>> DIV100_SH;
      return p[47:0];
   endfunction : div100

   function automatic logic [15:0] low16(input logic signed [47:0] x);
      return x[15:0];
   endfunction : low16

   always_comb begin
      nxt_s = s_ff;
      idx = paddr_i[11:2];
      fsrc = s_ff.cfg.src[SRC_FREQ_LSB +: 4];
      pidfb = s_ff.cfg.src[SRC_PIDFB_LSB +: 4];
      pidc = s_ff.cfg.src[SRC_PIDC_LSB +: 4];
      claim = (fsrc == SRC_AUX_V) || (fsrc == SRC_AUX_I) ||
              (pidfb == PID_FB_AUX_V) || (pidfb == PID_FB_AUX_I);
      err = (s_ff.cfg.func != FUNC_OFF) && (claim || pidc != 4'h0);
      on = (s_ff.cfg.func != FUNC_OFF) && !err;
      take = sample_valid_i && (s_ff.ph == PH_IDLE) &&
             (on || fsrc == SRC_AUX_V || fsrc == SRC_AUX_I);
      rp = s_ff.acc >>> Q_SH;
      t = div100(s_ff.acc);
      raw = (s_ff.cfg.itype == TYPE_CURR) ? curr_sample_i : volt_sample_i;
      sel_gain = (s_ff.cfg.itype == TYPE_CURR) ? s_ff.cfg.cgain :
                 s_ff.cfg.vgain;

      // APB decode
      hit = 1'b1;
      ro_hit = 1'b0;
      case (idx)
         IDX_PRESET2, IDX_MGAIN, IDX_MBIAS, IDX_VGAIN, IDX_VBIAS,
         IDX_CGAIN, IDX_CBIAS, IDX_FUNC, IDX_TYPE, IDX_SPAN,
         IDX_MAXF, IDX_SRC: begin
            ro_hit = 1'b0;
         end
         IDX_STAT, IDX_ERRC, IDX_REF: begin
            ro_hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      // Read data latched in setup so the access phase needs no wait
      if (psel_i && !penable_i) begin
         nxt_s.pslverr = !hit || (pwrite_i && ro_hit);
         nxt_s.prdata = 32'h0000_0000;
         case (idx)
            IDX_PRESET2: nxt_s.prdata[15:0] = s_ff.cfg.preset2;
            IDX_MGAIN: nxt_s.prdata[15:0] = s_ff.cfg.mgain;
            IDX_MBIAS: nxt_s.prdata[15:0] = s_ff.cfg.mbias;
            IDX_VGAIN: nxt_s.prdata[15:0] = s_ff.cfg.vgain;
            IDX_VBIAS: nxt_s.prdata[15:0] = s_ff.cfg.vbias;
            IDX_CGAIN: nxt_s.prdata[15:0] = s_ff.cfg.cgain;
            IDX_CBIAS: nxt_s.prdata[15:0] = s_ff.cfg.cbias;
            IDX_FUNC: nxt_s.prdata[15:0] = s_ff.cfg.func;
            IDX_TYPE: nxt_s.prdata[15:0] = s_ff.cfg.itype;
            IDX_SPAN: nxt_s.prdata[15:0] = s_ff.cfg.span;
            IDX_MAXF: nxt_s.prdata[15:0] = s_ff.cfg.maxf;
            IDX_SRC: nxt_s.prdata[15:0] = s_ff.cfg.src;
            IDX_STAT: begin
               nxt_s.prdata[STAT_ERR] = err;
               nxt_s.prdata[STAT_ON] = on;
               nxt_s.prdata[STAT_BUSY] = (s_ff.ph != PH_IDLE);
            end
            IDX_ERRC: nxt_s.prdata[15:0] = err ? ERR_CODE_SETTING :
                                           16'h0000;
            IDX_REF: nxt_s.prdata[15:0] = s_ff.ref_pct;
            default: nxt_s.prdata = 32'h0000_0000;
         endcase
      end

      // Writes land only at the completing access edge
      if (psel_i && penable_i && pwrite_i && hit && !ro_hit) begin
         case (idx)
            IDX_PRESET2: nxt_s.cfg.preset2 = pwdata_i[15:0];
            IDX_MGAIN: nxt_s.cfg.mgain = sat(pwdata_i[15:0], 0, GAIN_LIM);
            IDX_MBIAS: begin
               nxt_s.cfg.mbias = sat(pwdata_i[15:0], -MBIAS_LIM, MBIAS_LIM);
            end
            IDX_VGAIN: begin
               nxt_s.cfg.vgain = sat(pwdata_i[15:0], -GAIN_LIM, GAIN_LIM);
            end
            IDX_VBIAS: begin
               nxt_s.cfg.vbias = sat(pwdata_i[15:0], -BIAS_LIM, BIAS_LIM);
            end
            IDX_CGAIN: begin
               nxt_s.cfg.cgain = sat(pwdata_i[15:0], -GAIN_LIM, GAIN_LIM);
            end
            IDX_CBIAS: begin
               nxt_s.cfg.cbias = sat(pwdata_i[15:0], -BIAS_LIM, BIAS_LIM);
            end
            IDX_FUNC: nxt_s.cfg.func = sat(pwdata_i[15:0], 0, FUNC_MAX);
            IDX_TYPE: nxt_s.cfg.itype = sat(pwdata_i[15:0], 0, TYPE_MAX);
            IDX_SPAN: nxt_s.cfg.span = sat(pwdata_i[15:0], 0, SPAN_MAX);
            IDX_MAXF: nxt_s.cfg.maxf = pwdata_i[15:0];
            IDX_SRC: nxt_s.cfg.src = pwdata_i[15:0];
            default: nxt_s.cfg = s_ff.cfg;
         endcase
      end

      // Pin synchroniser, only the second stage is read
      nxt_s.sync = {s_ff.sync[0], step_two_sel_i};

      // Samples arriving while busy are dropped
      case (s_ff.ph)
         PH_IDLE: begin
            if (take) begin
               nxt_s.neg = sel_gain[15];
               nxt_s.mag = sel_gain[15] ? 8'(-sel_gain) : sel_gain[7:0];
               nxt_s.sb = (s_ff.cfg.itype == TYPE_CURR) ?
                          s_ff.cfg.cbias : s_ff.cfg.vbias;
               // Full code is one hundred percent
               nxt_s.acc = ($signed(48'(raw)) * PCT_FULL_Q8) >>> ADC_W;
               nxt_s.ph = PH_SUM;
            end
         end
         PH_SUM: begin
            nxt_s.acc = s_ff.acc + (48'($signed(s_ff.sb)) <<< Q_SH);
            nxt_s.ph = PH_MUL;
         end
         PH_MUL: begin
            // 48 bits hold 200 percent Q8 times 255
            nxt_s.acc = s_ff.acc * $signed(48'(s_ff.mag));
            nxt_s.ph = PH_SCALE;
         end
         PH_SCALE: begin
            nxt_s.acc = t;
            if (s_ff.neg) begin
               nxt_s.acc = PCT_FULL_Q8 - t;
            end
            if (s_ff.neg ? (t > PCT_FULL_Q8) : t[47]) begin
               nxt_s.acc = 48'sh0;
            end
            nxt_s.ph = PH_OUT;
         end
         PH_OUT: begin
            nxt_s.ref_pct = low16(rp);
            nxt_s.aux_freq = low16(div100(rp * $signed(48'(s_ff.cfg.maxf))));
            nxt_s.g_aux = low16(div100(rp * $signed(48'(s_ff.cfg.mgain))
                                       * 48'sh2));
            // Span as percent of maximum frequency
            nxt_s.b_aux = low16(48'($signed(s_ff.cfg.mbias)) +
                                div100((rp * 48'sh2 - PCT_100) *
                                       $signed(48'(s_ff.cfg.span))));
            nxt_s.v_aux = low16(div100(rp * VBIAS_FULL));
            nxt_s.ph = PH_IDLE;
         end
         default: begin
            nxt_s.ph = PH_IDLE;
         end
      endcase

      // Registered outputs
      nxt_s.o.ref_valid = (s_ff.ph == PH_OUT);
      nxt_s.o.set_err = err;
      // Result published with its valid pulse, not a cycle behind
      nxt_s.o.ref_pct = nxt_s.ref_pct;
      nxt_s.o.aux_freq = nxt_s.aux_freq;
      nxt_s.o.sel_aux = on && (s_ff.cfg.func == FUNC_AUX_REF) &&
                        s_ff.sync[1];
      nxt_s.o.freq_two = (on && s_ff.cfg.func == FUNC_AUX_REF) ?
                         s_ff.aux_freq : s_ff.cfg.preset2;
      // Main gain and bias stay active
      nxt_s.o.gain_eff = (on && s_ff.cfg.func == FUNC_GAIN) ?
                         s_ff.g_aux : s_ff.cfg.mgain;
      nxt_s.o.bias_eff = (on && s_ff.cfg.func == FUNC_BIAS) ?
                         s_ff.b_aux : s_ff.cfg.mbias;
      nxt_s.o.volt_bias = (on && s_ff.cfg.func == FUNC_VBIAS) ?
                          s_ff.v_aux : 16'h0000;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_ff <= '{ph: PH_IDLE, cfg: CFG_RST, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata_o = s_ff.prdata;
   assign pslverr_o = s_ff.pslverr;
   // Zero wait states, read data already latched at setup
   assign pready_o = 1'b1;
   assign ref_o = s_ff.o;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_OFF_NO_VBIAS: assert property (
      (s_ff.cfg.func == FUNC_OFF) |=> (ref_o.volt_bias == 16'h0000)
   ) else $error("Voltage bias present while function is off");

   AST_CLAIM_ERR: assert property (
      (s_ff.cfg.func != FUNC_OFF && fsrc == SRC_AUX_V) |=> ref_o.set_err
   ) else $error("Shared input claim did not raise error");

   AST_PID_ERR: assert property (
      (s_ff.cfg.func != FUNC_OFF && pidc != 4'h0) |=> ref_o.set_err
   ) else $error("PID with aux function did not raise error");

   AST_PRESET_PASS: assert property (
      (s_ff.cfg.func != FUNC_AUX_REF) |=>
         (ref_o.freq_two == $past(s_ff.cfg.preset2))
   ) else $error("Preset two not passed while aux reference off");

   AST_SEL_AUX: assert property (
      ##1 (ref_o.sel_aux == $past(on && s_ff.sync[1] &&
                                  s_ff.cfg.func == FUNC_AUX_REF))
   ) else $error("Multi-step selection wrong");

   AST_GAIN_PASS: assert property (
      (s_ff.cfg.func != FUNC_GAIN) |=>
         (ref_o.gain_eff == $past(s_ff.cfg.mgain))
   ) else $error("Main gain not passed through");

   AST_CLAMP: assert property (
      (s_ff.ph == PH_OUT) |-> !s_ff.acc[47]
   ) else $error("Negative reference after clamp");

   AST_NEG_FULL: assert property (
      (s_ff.ph == PH_SCALE && s_ff.neg && s_ff.acc == 48'sh0) |=>
         (s_ff.acc == PCT_FULL_Q8)
   ) else $error("Negative gain with zero input not full scale");

   AST_SAMPLE_LAT: assert property (
      take |-> ##5 ref_o.ref_valid
   ) else $error("Sample did not yield a reference in five cycles");

   AST_GAIN_RANGE: assert property (
      ($signed(s_ff.cfg.vgain) <= 16'sd255) &&
      ($signed(s_ff.cfg.vgain) >= -16'sd255)
   ) else $error("Voltage gain outside range");

endmodule : aais_top

// >>> tb_top.sv
// Self-checking bench for the auxiliary analog input scaler
`timescale 1ns/1ps
`define CHK(g, e, t) chk(g, e, t)
module tb_top;
   import aais_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
   logic req = 0, cur_s = 0, stp = 0, pready, pslverr, vld, err;
   logic [11:0] paddr = '0, code = '0, vs, cs;
   logic [31:0] pwdata = '0, prdata, rd;
   aais_out_type ref_q;
   int n_mismatch = 0, checks_done = 0;
   int mg = 120, mb = -20, sp = 10, mf = 500, pr2 = 291;
   logic [9:0] ridx [6] = '{IDX_VGAIN, IDX_VBIAS, IDX_CGAIN, IDX_CBIAS,
      IDX_SPAN, IDX_FUNC};
   int rval [6] = '{100, 0, 100, 0, 10, 0};
   logic [9:0] sidx [4] = '{IDX_VGAIN, IDX_CGAIN, IDX_VBIAS, IDX_SPAN};
   int swr [4] = '{300, -300, 150, 60};
   int sexp [4] = '{255, 'hff01, 100, 50};
   int esrc [5] = '{7, 8, 'h70, 'h80, 'h100};

   always #2.5 clk = ~clk;

   aais_top DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .volt_sample_i(vs), .curr_sample_i(cs), .sample_valid_i(vld),
      .step_two_sel_i(stp), .ref_o(ref_q));
   aais_src_model SRC (.sys_clk_i(clk), .rst_n_i(rst_n), .req_i(req),
      .curr_sel_i(cur_s), .code_i(code), .volt_sample_o(vs),
      .curr_sample_o(cs), .sample_valid_o(vld));

   task automatic chk(input logic signed [31:0] g, input int e, input int t);
      checks_done++;
      if ((^g === 1'bx) || (g > e + t) || (g < e - t)) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [9:0] idx,
                      input logic [15:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n >= 20) n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : apb

   // Source raises valid one edge after req; the next edge is the take
   task automatic sample(input logic [11:0] c, input logic cur,
                         output int k);
      code <= c;
      cur_s <= cur;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      @(posedge clk);
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (ref_q.ref_valid !== 1'b1 && k < 20);
   endtask : sample

   // Integer model of the scaled reference, percent in Q8
   function automatic int refq(int c, int g, int b);
      int r;
      r = (c * 25600 / 4096 + b * 256) * (g < 0 ? -g : g) / 100;
      if (g < 0) r = 25600 - r;
      return r < 0 ? 0 : r;
   endfunction : refq

   task automatic run(input logic [15:0] f, input logic cur,
                      input int c, input int g, input int b);
      int k, r, eb;
      apb(1, IDX_FUNC, f);
      apb(1, IDX_TYPE, {15'h0000, cur});
      apb(1, cur ? IDX_CGAIN : IDX_VGAIN, 16'(g));
      apb(1, cur ? IDX_CBIAS : IDX_VBIAS, 16'(b));
      stp <= 1'($urandom_range(1, 0));
      sample(12'(c), cur, k);
      r = refq(c, g, b);
      eb = (f == FUNC_BIAS) ? mb + (2 * r - 25600) * sp / 25600 : mb;
      `CHK(k, 4, 0);
      `CHK(ref_q.ref_pct, r / 256, 1);
      `CHK(ref_q.aux_freq, r * mf / 25600, 6);
      @(posedge clk);
      #1;
      `CHK(ref_q.freq_two, f == 1 ? r * mf / 25600 : pr2, 6);
      `CHK(ref_q.gain_eff, f == 2 ? mg * r / 12800 : mg, 3);
      `CHK($signed(ref_q.bias_eff), eb, 2);
      `CHK(ref_q.volt_bias, f == 4 ? r / 256 : 0, 1);
      `CHK(ref_q.sel_aux, f == 1 ? int'(stp) : 0, 0);
      @(posedge clk);
      apb(0, IDX_REF, 16'h0000);
      `CHK(rd, r / 256, 1);
   endtask : run

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report

   initial begin
      #(60000 * 5);
      n_mismatch++;
      final_report();
   end

   initial begin
      int k, g;
      void'($urandom(32'h195640f2));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (ridx[i]) begin
         apb(0, ridx[i], 16'h0000);
         `CHK(rd, rval[i], 0);
      end
      foreach (sidx[i]) begin
         apb(1, sidx[i], 16'(swr[i]));
         apb(0, sidx[i], 16'h0000);
         `CHK(rd, sexp[i], 0);
      end
      apb(0, 10'h3ff, 16'h0000);
      `CHK(err, 1, 0);
      apb(1, IDX_STAT, 16'h0000);
      `CHK(err, 1, 0);
      apb(1, IDX_SPAN, 16'(sp));
      apb(1, IDX_MGAIN, 16'(mg));
      apb(1, IDX_MBIAS, 16'(mb));
      apb(1, IDX_PRESET2, 16'(pr2));
      foreach (esrc[i]) begin
         apb(1, IDX_SRC, 16'(esrc[i]));
         apb(1, IDX_FUNC, FUNC_AUX_REF);
         apb(0, IDX_ERRC, 16'h0000);
         `CHK(rd, ERR_CODE_SETTING, 0);
         apb(0, IDX_STAT, 16'h0000);
         `CHK(rd, 1 << STAT_ERR, 0);
         `CHK(ref_q.set_err, 1, 0);
         apb(1, IDX_FUNC, FUNC_OFF);
         `CHK(ref_q.set_err, 0, 0);
      end
      apb(1, IDX_SRC, 16'h0000);
      sample(12'h800, 1'b0, k);
      `CHK(k, 20, 0);
      @(posedge clk);
      apb(1, IDX_SRC, 16'h0007);
      run(FUNC_OFF, 1'b0, 2048, 100, 0);
      apb(1, IDX_SRC, 16'h0000);
      run(FUNC_BIAS, 1'b0, 2048, 100, -100);
      run(FUNC_GAIN, 1'b1, 3072, -200, 0);
      run(FUNC_VBIAS, 1'b0, 0, -50, 0);
      for (int i = 0; i < 12; i++) begin
         g = $urandom_range(100, 1);
         if ($urandom_range(1, 0) == 1) g = -g;
         run(16'(1 + i % 4), 1'($urandom_range(1, 0)),
             $urandom_range(3276, 0), g, $urandom_range(20, 0));
      end
      final_report();
   end
endmodule : tb_top
